/* pkg/sfg_link_if.sv */
`timescale 1ns/1ps
interface sfg_link_if;
  logic sck;
  logic cs_n;
  logic mosi;
  logic miso_o;
  logic miso_oe;
  logic data_line_two;
  wire miso;
  // pulled up while the device does not drive
  assign miso = miso_oe ? miso_o : 1'b1;
  modport device (
    input sck,
    input cs_n,
    input mosi,
    input data_line_two,
    input miso,
    output miso_o,
    output miso_oe
  );
  modport host (
    output sck,
    output cs_n,
    output mosi,
    output data_line_two,
    input miso
  );
endinterface : sfg_link_if

/* pkg/sfg_pkg.sv */
// Function
// (RL1) only clock modes 0 and 3 used
// (RL2) sample on rising, launch on falling edge
// (RL3) clock idle while select high
// (RL4) 0Fh reads, 1Fh writes, one address byte
// (RL5) features survive soft reset FFh
// (RL6) guard register fully writable, volatile
// (RL7) host sets fields before guard bits
// (RL8) all guard bits zero: pin is data
// (RL9) high guard bit: pin low blocks changes
// (RL10) low guard bit alone: guard locked
// (RL11) both guard bits: freeze settable, locks
// (RL12) hardware enable: pin guards, no x4
// (RL13) hardware enable, pin low: read-only
// (RL14) power cycle clears guard bits
// (RL15) range zero: nothing locked
// (RL16) low-end zero: top fraction locked
// (RL17) low-end one: bottom fraction locked
// (RL18) bit3 with bit2 or bit1: all locked
// (RL19) unlisted codes lock everything
// (RL20) locked program or erase ignored
// (RL21) locked attempt sets fail flag
package sfg_pkg;
  // =====================================================
  // link commands and feature addresses
  localparam logic [7:0] CMD_FEAT_RD = 8'h0f;
  localparam logic [7:0] CMD_FEAT_WR = 8'h1f;
  localparam logic [7:0] CMD_SOFT_RST = 8'hff;
  localparam logic [7:0] CMD_WR_EN = 8'h06;
  localparam logic [7:0] CMD_WR_DIS = 8'h04;
  localparam logic [7:0] FA_GUARD = 8'ha0;
  localparam logic [7:0] FA_DEVCFG = 8'hb0;
  localparam logic [7:0] FA_STATUS = 8'hc0;
  localparam logic [7:0] FA_DRIVE = 8'hd0;
  // =====================================================
  // field positions
  localparam int GB_HI = 7;
  localparam int GB_RANGE = 3;
  localparam int GB_LOWEND = 2;
  localparam int GB_HWEN = 1;
  localparam int GB_LO = 0;
  localparam int CB_FREEZE = 5;
  localparam logic [7:0] CFG_WMASK = 8'hd0;
  localparam logic [7:0] DRV_WMASK = 8'h60;
  localparam int SB_PFAIL = 3;
  localparam int SB_EFAIL = 2;
  localparam int SB_WEL = 1;
  // =====================================================
  // reset values
  localparam logic [7:0] GUARD_RST = 8'h7c;
  localparam logic [7:0] DEVCFG_RST = 8'h10;
  localparam logic [7:0] DRIVE_RST = 8'h20;
  // =====================================================
  // host register offsets and timing
  localparam logic [3:0] OFS_CMD = 4'h0;
  localparam logic [3:0] OFS_STAT = 4'h4;
  localparam logic [3:0] OFS_PINS = 4'h8;
  localparam int SCK_HALF_CYCLES = 8;
endpackage : sfg_pkg

/* rtl/sfg_device.sv */
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module sfg_device
  import sfg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  sfg_link_if.device link,
  input wire logic op_req,
  input wire logic op_is_erase,
  input wire logic [9:0] op_block,
  output logic op_accept,
  output logic op_reject,
  output logic x4_enable,
  output logic read_only
);
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_WDATA, ST_RDATA, ST_SKIP
  } sfg_state_t;

  // =====================================================
  // pin synchronisers
  logic [1:0] sck_s;
  logic [1:0] cs_s;
  logic [1:0] mosi_s;
  logic [1:0] pin_s;
  logic sck_d;
  logic sck_rise;
  logic sck_fall;
  logic sel;

  // two flops per pin, edge history from second stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_s <= 2'h0;
      cs_s <= 2'h3;
      mosi_s <= 2'h0;
      pin_s <= 2'h3;
      sck_d <= 1'b0;
    end else begin
      sck_s <= {sck_s[0], link.sck};
      cs_s <= {cs_s[0], link.cs_n};
      mosi_s <= {mosi_s[0], link.mosi};
      pin_s <= {pin_s[0], link.data_line_two};
      sck_d <= sck_s[1];
    end
  end

  assign sel = ~cs_s[1];
  assign sck_rise = sel & sck_s[1] & ~sck_d;  // RL2
  assign sck_fall = sel & ~sck_s[1] & sck_d;  // RL2

  // =====================================================
  // feature state and guard decode
  logic [7:0] guard;
  logic [7:0] devcfg;
  logic [7:0] drive;
  logic pfail;
  logic efail;
  logic write_latch;
  logic [7:0] next_guard;
  logic [7:0] next_devcfg;
  logic [7:0] next_drive;
  logic next_pfail;
  logic next_efail;
  logic next_wel;
  logic all_ro;
  logic guard_lock;
  logic both_guard;
  logic [3:0] rsel;
  logic [9:0] hi_mask;
  logic in_range;
  logic op_locked;

  assign rsel = guard[GB_RANGE +: 4];
  assign both_guard = guard[GB_HI] & guard[GB_LO];
  // pin low with hardware enable makes everything read-only
  assign all_ro = guard[GB_HWEN] & ~pin_s[1];  // RL13
  assign x4_enable = ~guard[GB_HWEN];  // RL12
  assign read_only = all_ro;
  // guard register write lockout
  assign guard_lock = devcfg[CB_FREEZE]  // RL11
    | guard[GB_LO]  // RL10
    | (guard[GB_HI] & ~guard[GB_HWEN] & ~pin_s[1]);  // RL9 RL8

  // locked block range
  always_comb begin
    hi_mask = 10'h3ff << rsel;
    in_range = 1'b0;
    if (rsel == 4'h0) begin
      in_range = 1'b0;  // RL15
    end else if (rsel[3] & (rsel[2] | rsel[1])) begin
      in_range = 1'b1;  // RL18 RL19
    end else if (guard[GB_LOWEND]) begin
      in_range = (op_block & hi_mask) == 10'h000;  // RL17
    end else begin
      in_range = (op_block & hi_mask) == hi_mask;  // RL16
    end
  end

  assign op_locked = all_ro | in_range;  // RL20

  // =====================================================
  // serial shifter state
  sfg_state_t state;
  sfg_state_t next_state;
  logic [2:0] bitcnt;
  logic [2:0] next_bitcnt;
  logic [7:0] rx;
  logic [7:0] next_rx;
  logic [7:0] opcode;
  logic [7:0] next_opcode;
  logic [7:0] faddr;  // feature address kept through the data byte
  logic [7:0] next_faddr;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic miso_q;
  logic next_miso_q;
  logic next_op_accept;
  logic next_op_reject;
  logic [7:0] byte_in;
  logic byte_done;

  assign byte_in = {rx[6:0], mosi_s[1]};
  assign byte_done = sck_rise & (bitcnt == 3'h7);

  // feature read mux
  function automatic logic [7:0] feat_rd(input logic [7:0] a,
      input logic [7:0] g, input logic [7:0] c,
      input logic [7:0] st, input logic [7:0] d);
    feat_rd = 8'h00;
    if (a == FA_GUARD) feat_rd = g;
    else if (a == FA_DEVCFG) feat_rd = c;
    else if (a == FA_STATUS) feat_rd = st;
    else if (a == FA_DRIVE) feat_rd = d;
  endfunction : feat_rd

  // next state of shifter and feature registers
  always_comb begin
    next_state = state;
    next_bitcnt = bitcnt;
    next_rx = rx;
    next_opcode = opcode;
    next_faddr = faddr;
    next_tx = tx;
    next_miso_q = miso_q;
    next_guard = guard;
    next_devcfg = devcfg;
    next_drive = drive;
    next_pfail = pfail;
    next_efail = efail;
    next_wel = write_latch;
    next_op_accept = 1'b0;
    next_op_reject = 1'b0;
    if (!sel) begin
      next_state = ST_CMD;
      next_bitcnt = 3'h0;
    end else if (sck_rise) begin
      next_rx = byte_in;
      next_bitcnt = bitcnt + 3'h1;
    end
    if (sck_fall && state == ST_RDATA) begin
      next_miso_q = tx[7];  // RL2
      next_tx = {tx[6:0], tx[7]};
    end
    if (byte_done) begin
      unique case (state)
        ST_CMD: begin
          next_opcode = byte_in;
          next_state = ST_SKIP;
          if (byte_in == CMD_FEAT_RD || byte_in == CMD_FEAT_WR) begin
            next_state = ST_ADDR;  // RL4
          end else if (byte_in == CMD_WR_EN) begin
            next_wel = ~all_ro;
          end else if (byte_in == CMD_WR_DIS) begin
            next_wel = 1'b0;
          end else if (byte_in == CMD_SOFT_RST) begin
            // features kept, only status cleared
            next_pfail = 1'b0;  // RL5
            next_efail = 1'b0;
            next_wel = 1'b0;
          end
        end
        ST_ADDR: begin
          next_faddr = byte_in;  // RL4
          if (opcode == CMD_FEAT_RD) begin
            next_state = ST_RDATA;
            next_tx = feat_rd(byte_in, guard, devcfg,
              {4'h0, pfail, efail, write_latch, 1'b0}, drive);
          end else begin
            next_state = ST_WDATA;
          end
        end
        ST_WDATA: begin
          next_state = ST_SKIP;
          if (!all_ro) begin  // RL13
            if (faddr == FA_GUARD && !guard_lock) begin
              next_guard = byte_in;  // RL6
            end else if (faddr == FA_DEVCFG) begin
              next_devcfg = (byte_in & CFG_WMASK)
                | (devcfg & ~CFG_WMASK);
              // freeze only when both guard bits set, sticky
              next_devcfg[CB_FREEZE] = devcfg[CB_FREEZE]
                | (both_guard & byte_in[CB_FREEZE]);  // RL11
            end else if (faddr == FA_DRIVE) begin
              next_drive = (byte_in & DRV_WMASK)
                | (drive & ~DRV_WMASK);
            end
          end
        end
        ST_RDATA, ST_SKIP: begin
          next_state = state;
        end
      endcase
    end
    // array request after link updates so its flag wins
    if (op_req) begin
      if (op_locked) begin
        next_op_reject = 1'b1;  // RL20
        if (op_is_erase) next_efail = 1'b1;  // RL21
        else next_pfail = 1'b1;  // RL21
      end else if (!write_latch) begin
        next_op_reject = 1'b1;
      end else begin
        next_op_accept = 1'b1;
        next_wel = 1'b0;
        if (op_is_erase) next_efail = 1'b0;
        else next_pfail = 1'b0;
      end
    end
  end

  // register the shifter and features; reset is power-up
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_CMD;
      bitcnt <= 3'h0;
      rx <= 8'h00;
      opcode <= 8'h00;
      faddr <= 8'h00;
      tx <= 8'h00;
      miso_q <= 1'b1;
      guard <= GUARD_RST;  // RL14
      devcfg <= DEVCFG_RST;
      drive <= DRIVE_RST;
      pfail <= 1'b0;
      efail <= 1'b0;
      write_latch <= 1'b0;
      op_accept <= 1'b0;
      op_reject <= 1'b0;
    end else begin
      state <= next_state;
      bitcnt <= next_bitcnt;
      rx <= next_rx;
      opcode <= next_opcode;
      faddr <= next_faddr;
      tx <= next_tx;
      miso_q <= next_miso_q;
      guard <= next_guard;
      devcfg <= next_devcfg;
      drive <= next_drive;
      pfail <= next_pfail;
      efail <= next_efail;
      write_latch <= next_wel;
      op_accept <= next_op_accept;
      op_reject <= next_op_reject;
    end
  end

  // drive serial out only during feature read data
  assign link.miso_o = miso_q;
  assign link.miso_oe = sel & (state == ST_RDATA);
endmodule : sfg_device

/* rtl/sfg_host.sv */
`timescale 1ns/1ps
module sfg_host
  import sfg_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYCLES
)(
  input wire logic aclk,
  input wire logic aresetn,
  sfg_link_if.host link,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  typedef enum logic [1:0] {HS_IDLE, HS_RUN, HS_GAP} sfg_hstate_t;

  // =====================================================
  // registers and state
  sfg_hstate_t st;
  sfg_hstate_t next_st;
  logic [23:0] txsh;
  logic [23:0] next_txsh;
  logic [7:0] rxsh;
  logic [7:0] next_rxsh;
  logic [4:0] nbits;
  logic [4:0] next_nbits;
  logic [4:0] cnt;
  logic [4:0] next_cnt;
  logic [7:0] tmr;
  logic [7:0] next_tmr;
  logic sck;
  logic next_sck;
  logic mode3;
  logic next_mode3;
  logic pin;
  logic next_pin;
  logic [1:0] miso_s;
  logic wr_go;
  logic rd_go;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic [7:0] op;

  // serial input synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) miso_s <= 2'h3;
    else miso_s <= {miso_s[0], link.miso};
  end

  // =====================================================
  // axi4-lite slave handshakes
  assign wr_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_bvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready = wr_go;
  assign rd_go = s_axi_arvalid & ~s_axi_rvalid;
  assign s_axi_arready = rd_go;
  assign op = s_axi_wdata[7:0];

  // next state of bus, command shifter and clock
  always_comb begin
    next_st = st;
    next_txsh = txsh;
    next_rxsh = rxsh;
    next_nbits = nbits;
    next_cnt = cnt;
    next_tmr = tmr;
    next_sck = sck;
    next_mode3 = mode3;
    next_pin = pin;
    next_bvalid = s_axi_bvalid & ~s_axi_bready;
    next_bresp = s_axi_bresp;
    next_rvalid = s_axi_rvalid & ~s_axi_rready;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (wr_go) begin
      next_bvalid = 1'b1;
      next_bresp = 2'b00;
      if (s_axi_awaddr == OFS_CMD && st == HS_IDLE) begin
        if (s_axi_wstrb[0]) begin
          next_st = HS_RUN;
          next_txsh = {op, s_axi_wdata[15:8], s_axi_wdata[23:16]};
          next_cnt = 5'h0;
          next_tmr = 8'h00;
          if (op == CMD_FEAT_WR) next_nbits = 5'd24;  // RL4
          else if (op == CMD_FEAT_RD) next_nbits = 5'd24;  // RL4
          else next_nbits = 5'd8;
        end
      end else if (s_axi_awaddr == OFS_PINS && st == HS_IDLE) begin
        if (s_axi_wstrb[0]) begin
          next_pin = s_axi_wdata[0];
          next_mode3 = s_axi_wdata[1];  // RL1
          next_sck = s_axi_wdata[1];  // RL3
        end
      end else begin
        next_bresp = 2'b10;
      end
    end
    if (rd_go) begin
      next_rvalid = 1'b1;
      next_rresp = 2'b00;
      next_rdata = 32'h0;
      if (s_axi_araddr == OFS_STAT) begin
        next_rdata = {16'h0, rxsh, 7'h0, st != HS_IDLE};
      end else if (s_axi_araddr == OFS_PINS) begin
        next_rdata = {30'h0, mode3, pin};
      end else if (s_axi_araddr != OFS_CMD) begin
        next_rresp = 2'b10;
      end
    end
    if (st != HS_IDLE) begin
      next_tmr = tmr + 8'h1;
    end
    if (st != HS_IDLE && tmr == 8'(HALF - 1)) begin
      next_tmr = 8'h00;
      if (st == HS_GAP) begin
        next_st = HS_IDLE;
      end else if (!sck) begin
        // rising edge: sample device data
        next_sck = 1'b1;
        next_rxsh = {rxsh[6:0], miso_s[1]};  // RL2
        next_cnt = cnt + 5'h1;
      end else if (cnt == nbits) begin
        // last half period done: clock back to idle, select released
        next_sck = mode3;  // RL3
        next_st = HS_GAP;
      end else begin
        // falling edge: launch next bit
        next_sck = 1'b0;
        if (cnt != 5'h0) next_txsh = {txsh[22:0], 1'b0};
      end
    end
  end

  // register bus and shifter state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= HS_IDLE;
      txsh <= 24'h0;
      rxsh <= 8'h00;
      nbits <= 5'h0;
      cnt <= 5'h0;
      tmr <= 8'h00;
      sck <= 1'b0;
      mode3 <= 1'b0;
      pin <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else begin
      st <= next_st;
      txsh <= next_txsh;
      rxsh <= next_rxsh;
      nbits <= next_nbits;
      cnt <= next_cnt;
      tmr <= next_tmr;
      sck <= next_sck;
      mode3 <= next_mode3;
      pin <= next_pin;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // link pins; clock held at idle level outside frames
  assign link.sck = sck;  // RL3
  assign link.cs_n = (st != HS_RUN);
  assign link.mosi = txsh[23];
  assign link.data_line_two = pin;
endmodule : sfg_host

/* test/sfg_link_checker.sv */
`timescale 1ns/1ps
// ==========================================================
// link protocol checks on the joined interface
module sfg_link_checker
  import sfg_pkg::*;
#(
  parameter int HALF = SCK_HALF_CYCLES
)(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic sck,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_o,
  input wire logic miso_oe,
  input wire logic data_line_two
);
  logic sck_q;
  logic next_sck_q;
  logic [4:0] rise_cnt;
  logic [4:0] next_rise_cnt;
  logic [5:0] gap_cnt;
  logic [5:0] next_gap_cnt;
  // rising edges within a frame and cycles since the last clock change
  always_comb begin
    next_sck_q = sck;
    next_rise_cnt = cs_n ? 5'h00 : rise_cnt + {4'h0, sck & ~sck_q};
    next_gap_cnt = (sck != sck_q) ? 6'h00 :
                   gap_cnt + {5'h00, gap_cnt != 6'h3f};
  end
  // register the tracking state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sck_q <= 1'b0;
      rise_cnt <= 5'h00;
      gap_cnt <= 6'h00;
    end else begin
      sck_q <= next_sck_q;
      rise_cnt <= next_rise_cnt;
      gap_cnt <= next_gap_cnt;
    end
  end
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // assertions
  a_select_quiet: assert property (
    $fell(cs_n) |-> $stable(sck) [*4]) else $error("clock moved at select");
  a_frame_bits: assert property (
    $rose(cs_n) |-> (rise_cnt == 5'd8 || rise_cnt == 5'd24))
    else $error("frame length is not 8 or 24 bits");
  a_drive_start: assert property (
    $rose(miso_oe) |-> rise_cnt == 5'd16)
    else $error("read data did not follow the address byte");
  a_drive_release: assert property (
    $rose(cs_n) |-> ##[1:6] !miso_oe) else $error("device kept driving");
  a_launch_low: assert property (
    miso_oe && $past(miso_oe) && $changed(miso_o) |-> !sck)
    else $error("device data changed while clock high");
  a_mosi_setup: assert property (
    !cs_n && !$past(cs_n) && $changed(mosi) |-> !sck)
    else $error("host data changed while clock high");
  a_half_period: assert property (
    (sck != sck_q) && rise_cnt != 5'd0 |-> gap_cnt == HALF - 1)
    else $error("clock half period wrong");
  a_pin_frame: assert property (
    !cs_n && !$past(cs_n) |-> $stable(data_line_two))
    else $error("guard pin moved in a frame");
  c_long_frame: cover property ($rose(cs_n) && rise_cnt == 5'd24);
  c_short_frame: cover property ($rose(cs_n) && rise_cnt == 5'd8);
  c_read_drive: cover property ($rose(miso_oe));
  c_mode3_frame: cover property ($fell(cs_n) && sck);
endmodule : sfg_link_checker

/* test/spi_flash_feature_block_guard_tb.sv */
`timescale 1ns/1ps
// ==========================================================
// host and device joined, driven through the host register bus
module spi_flash_feature_block_guard_tb import sfg_pkg::*;;
  localparam int HALF = 8;
  localparam logic [7:0] CG [11] = '{8'h04, 8'h08, 8'h08, 8'h0c, 8'h0c,
    8'h48, 8'h48, 8'h4c, 8'h50, 8'h60, 8'h58};
  localparam logic [9:0] CB [11] = '{10'd0, 10'd1022, 10'd1021, 10'd1,
    10'd2, 10'd512, 10'd511, 10'd511, 10'd0, 10'd1023, 10'd0};
  localparam logic CR [11] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0,
    1'b1, 1'b1, 1'b1, 1'b1};
  logic aclk = 1'b0, aresetn = 1'b0, op_req = 1'b0, op_is_erase = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [9:0] op_block = 10'h000;
  logic awready, wready, bvalid, arready, rvalid;
  logic op_accept, op_reject, x4_enable, read_only;
  logic [1:0] bresp, rresp, r;
  logic [31:0] rdata, d;
  int fail_count = 0, num_checks = 0;
  // clock source
  always #25 aclk = ~aclk;
  sfg_link_if link();
  sfg_host #(.HALF(HALF)) sfg_host_inst(.aclk(aclk), .aresetn(aresetn),
    .link(link), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  sfg_device sfg_device_inst(.aclk(aclk), .aresetn(aresetn), .link(link),
    .op_req(op_req), .op_is_erase(op_is_erase), .op_block(op_block),
    .op_accept(op_accept), .op_reject(op_reject), .x4_enable(x4_enable),
    .read_only(read_only));
  sfg_link_checker #(.HALF(HALF)) chk_inst(.aclk(aclk), .aresetn(aresetn),
    .sck(link.sck), .cs_n(link.cs_n), .mosi(link.mosi),
    .miso_o(link.miso_o), .miso_oe(link.miso_oe),
    .data_line_two(link.data_line_two));
  // ==========================================================
  // tasks
  task chk(input string what, input logic [31:0] seen,
           input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask : chk
  task final_report;
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report
  task axi_wr(input logic [3:0] a, input logic [31:0] v,
              output logic [1:0] resp);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      @(negedge aclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask : axi_wr
  task axi_rd(input logic [3:0] a, output logic [31:0] v,
              output logic [1:0] resp);
    logic ta, tr;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      @(negedge aclk);
      ta = arvalid & arready;
      tr = rvalid;
      v = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask : axi_rd
  // one frame on the link, then wait until the host is idle again
  task run(input logic [31:0] w);
    int n;
    axi_wr(OFS_CMD, w, r);
    n = 0;
    do begin
      axi_rd(OFS_STAT, d, r);
      n++;
    end while (d[0] !== 1'b0 && n < 2000);
    chk("host idle", {31'h0, d[0]}, 32'h0);
  endtask : run
  task fw(input logic [7:0] fa, input logic [7:0] v);
    run({8'h00, v, fa, CMD_FEAT_WR});
  endtask : fw
  task fr_chk(input string what, input logic [7:0] fa,
              input logic [7:0] mask, input logic [7:0] exp);
    run({16'h0000, fa, CMD_FEAT_RD});
    axi_rd(OFS_STAT, d, r);
    chk(what, {24'h0, d[15:8] & mask}, {24'h0, exp});
  endtask : fr_chk
  task pins(input logic [1:0] v);
    axi_wr(OFS_PINS, {30'h0, v}, r);
    repeat (4) @(posedge aclk);
  endtask : pins
  task op(input logic [9:0] blk, input logic er, input logic rej);
    @(posedge aclk);
    op_req <= 1'b1;
    op_is_erase <= er;
    op_block <= blk;
    @(posedge aclk);
    op_req <= 1'b0;
    #1;
    chk("op_reject", {31'h0, op_reject}, {31'h0, rej});
    chk("op_accept", {31'h0, op_accept}, {31'h0, !rej});
  endtask : op
  task por;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
  endtask : por
  // ==========================================================
  // test sequence
  initial begin
    por();
    fr_chk("guard", FA_GUARD, 8'hff, GUARD_RST);
    fr_chk("devcfg", FA_DEVCFG, 8'hff, DEVCFG_RST);
    fr_chk("drive", FA_DRIVE, 8'hff, DRIVE_RST);
    fr_chk("status", FA_STATUS, 8'hff, 8'h00);
    axi_wr(4'hc, 32'h0, r);
    chk("bresp", {30'h0, r}, 32'h2);
    axi_rd(4'hc, d, r);
    chk("rresp", {30'h0, r}, 32'h2);
    chk("rdata", d, 32'h0);
    $display("test defaults done");
    for (int i = 0; i < 11; i++) begin
      fw(FA_GUARD, CG[i]);
      fr_chk("guard back", FA_GUARD, 8'hff, CG[i]);
      run({24'h0, CMD_WR_EN});
      op(CB[i], i[0], CR[i]);
      if (CR[i]) begin
        fr_chk("fail flag", FA_STATUS, i[0] ? 8'h04 : 8'h08,
               i[0] ? 8'h04 : 8'h08);
      end
    end
    $display("test ranges done");
    run({24'h0, CMD_SOFT_RST});
    fr_chk("guard kept", FA_GUARD, 8'hff, 8'h58);
    fr_chk("status cleared", FA_STATUS, 8'hff, 8'h00);
    $display("test soft reset done");
    fw(FA_GUARD, 8'h80);
    pins(2'b00);
    chk("read_only", {31'h0, read_only}, 32'h0);
    fw(FA_GUARD, 8'h00);
    fr_chk("pin blocks", FA_GUARD, 8'hff, 8'h80);
    pins(2'b01);
    fw(FA_GUARD, 8'h00);
    fr_chk("pin permits", FA_GUARD, 8'hff, 8'h00);
    chk("x4_enable", {31'h0, x4_enable}, 32'h1);
    fw(FA_GUARD, 8'h02);
    chk("x4_enable", {31'h0, x4_enable}, 32'h0);
    pins(2'b00);
    chk("read_only", {31'h0, read_only}, 32'h1);
    fw(FA_GUARD, 8'h00);
    fr_chk("read only guard", FA_GUARD, 8'hff, 8'h02);
    run({24'h0, CMD_WR_EN});
    op(10'd5, 1'b0, 1'b1);
    pins(2'b01);
    fw(FA_GUARD, 8'h00);
    fr_chk("hw pin high", FA_GUARD, 8'hff, 8'h00);
    $display("test pin guard done");
    fw(FA_GUARD, 8'h01);
    fw(FA_GUARD, 8'h00);
    fr_chk("lo locked", FA_GUARD, 8'hff, 8'h01);
    por();
    fr_chk("power cycle", FA_GUARD, 8'hff, GUARD_RST);
    fw(FA_GUARD, 8'h81);
    fw(FA_DEVCFG, 8'h30);
    fr_chk("freeze set", FA_DEVCFG, 8'hff, 8'h30);
    fw(FA_GUARD, 8'h00);
    fr_chk("frozen guard", FA_GUARD, 8'hff, 8'h81);
    por();
    fr_chk("freeze gone", FA_DEVCFG, 8'hff, DEVCFG_RST);
    $display("test locks done");
    pins(2'b11);
    fr_chk("mode3 read", FA_GUARD, 8'hff, GUARD_RST);
    pins(2'b01);
    $display("test mode3 done");
    final_report();
  end
  // watchdog against a hung handshake
  initial begin
    repeat (90000) @(posedge aclk);
    fail_count++;
    final_report();
  end
endmodule : spi_flash_feature_block_guard_tb
